// ### iis_action_timer.sv
// Counts the twelve actions of a memory cycle.
// Assumes a synchronous active-high reset; holds at the last action when
// stopped so that a restart begins with a fresh cycle.
`timescale 1ns/100ps
`default_nettype none
module iis_action_timer
    import iis_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Control
    input wire logic run,
    // Current action
    output logic [3:0] action
);
    always_ff @(posedge core_clk) begin
        if (reset) begin
            action <= IIS_ACTION_LAST;
        end else if (!run) begin
            action <= IIS_ACTION_LAST;
        end else if (action == IIS_ACTION_LAST) begin
            action <= IIS_ACTION_FIRST;
        end else begin
            action <= action + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ### iis_adder_if.sv
// Carrier between the sequencer and its one's-complement adder.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface iis_adder_if;
    logic [15:0] operandX;
    logic [15:0] operandY;
    logic carryIn;
    logic [15:0] sum;
    logic sumParity;
    modport user (output operandX, output operandY, output carryIn,
        input sum, input sumParity);
    modport adder (input operandX, input operandY, input carryIn,
        output sum, output sumParity);
endinterface
`default_nettype wire

// ### iis_mem_model.sv
// Erasable memory on the sequencer's far side.
// Read word is registered, one cycle after the address.
`timescale 1ns/100ps
`default_nettype none
module iis_mem_model (
    // Memory port
    input wire logic core_clk,
    input wire logic [11:0] memAddr,
    input wire logic memWriteEnable,
    input wire logic [14:0] memWriteData,
    input wire logic memWriteParity,
    output logic [14:0] memReadData,
    output logic memReadParity
);
    logic [15:0] mem [4096];
    // Zero words with good parity, so that fetches see known data
    initial foreach (mem[i]) mem[i] = 16'h8000;
    always @(posedge core_clk) begin
        if (memWriteEnable) mem[memAddr] <= {memWriteParity, memWriteData};
        {memReadParity, memReadData} <= mem[memAddr];
    end
endmodule
`default_nettype wire

// ### iis_ones_adder.sv
// Sixteen-bit one's-complement adder with end-around carry.
// Also generates odd parity over bit 16 and bits 14 to 1, the 15 bits that go back to memory unless bit 15 is kept.
`timescale 1ns/100ps
`default_nettype none
module iis_ones_adder (
    iis_adder_if.adder bus
);
    logic [16:0] rawSum;
    logic [16:0] wrapped;
    logic [14:0] stored;

    always_comb begin
        rawSum = {1'b0, bus.operandX} + {1'b0, bus.operandY}
            + {16'h0000, bus.carryIn};
        wrapped = {1'b0, rawSum[15:0]} + {16'h0000, rawSum[16]};
        bus.sum = wrapped[15:0];
        // Bit 16 of the sum lands in position 15 of the stored word
        stored = {wrapped[15], wrapped[13:0]};
        bus.sumParity = ~^stored;
    end
endmodule
`default_nettype wire

// ### iis_pkg.sv
// Constants and types shared by the involuntary instruction sequencer.
// Assumes one 10 MHz core clock and a 15-bit word with separate parity.
package iis_pkg;

    // Twelve actions make one memory cycle
    localparam logic [3:0] IIS_ACTION_FIRST = 4'h1;
    localparam logic [3:0] IIS_ACTION_LAST = 4'hC;

    // Fixed locations and constants (octal values kept as written)
    localparam logic [11:0] IIS_ADDR_SAVE_NEXT = 12'o0024;
    localparam logic [11:0] IIS_ADDR_SAVE_WORD = 12'o0025;
    localparam logic [11:0] IIS_ADDR_UPLINK = 12'o0041;
    localparam logic [11:0] IIS_ADDR_REVERSE_LO = 12'o0047;
    localparam logic [11:0] IIS_ADDR_REVERSE_HI = 12'o0053;
    localparam logic [2:0] IIS_RESUME_ORDER = 3'h2;
    localparam logic [15:0] IIS_CONST_PLUS_ONE = 16'o000001;
    localparam logic [15:0] IIS_CONST_MINUS_ONE = 16'o177776;

    // APB register byte offsets
    localparam logic [7:0] IIS_REG_CONTROL = 8'h00;
    localparam logic [7:0] IIS_REG_STATUS = 8'h04;
    localparam logic [7:0] IIS_REG_COUNTER = 8'h08;
    localparam logic [7:0] IIS_REG_BUFFER = 8'h0C;

    // Control fields and reset value
    localparam int IIS_CTL_RUN = 0;
    localparam int IIS_CTL_INHIBIT = 1;
    localparam logic [1:0] IIS_CONTROL_RESET = 2'h0;

    // Status fields
    localparam int IIS_STA_IN_PROGRESS = 0;
    localparam int IIS_STA_PARITY = 1;
    localparam int IIS_STA_STEP = 4;
    localparam int IIS_STA_ORDER = 8;
    localparam int IIS_STA_ACTION = 12;

    typedef enum logic [2:0] {
        IIS_STEP_FETCH = 3'b000,
        IIS_STEP_ENTRY_ONE = 3'b001,
        IIS_STEP_ENTRY_TWO = 3'b010,
        IIS_STEP_INDEX = 3'b011,
        IIS_STEP_RESUME = 3'b100,
        IIS_STEP_COUNTER = 3'b101
    } iis_step_type;

    typedef enum logic [1:0] {
        IIS_CNT_INCREMENT = 2'b00,
        IIS_CNT_DECREMENT = 2'b01,
        IIS_CNT_SHIFT = 2'b10,
        IIS_CNT_SHIFT_ADD_ONE = 2'b11
    } iis_counter_kind_type;

endpackage

// ### iis_properties.sv
// Port timing checker for the involuntary instruction sequencer.
// Bound to every iis_sequencer; single clock, synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module iis_properties
    import iis_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Watched ports
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [11:0] memAddr,
    input wire logic memWriteEnable,
    input wire logic [14:0] memWriteData,
    input wire logic memWriteParity,
    input wire logic uplinkInterruptProgram,
    input wire logic counterPriorityReset,
    input wire logic counterOverflow,
    input wire logic overflowTestPulse,
    input wire logic [1:0] overflowTestBits
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_write_parity: assert property (
        memWriteEnable |-> memWriteParity == ~^memWriteData)
        else $error("write parity not odd");
    a_reset_write: assert property (
        counterPriorityReset |-> memWriteEnable)
        else $error("priority reset without write back");
    a_reset_test: assert property (
        counterPriorityReset |-> overflowTestPulse)
        else $error("priority reset without overflow test");
    a_ovf_bits: assert property (
        counterOverflow |-> overflowTestPulse &&
        overflowTestBits[1] != overflowTestBits[0])
        else $error("overflow without differing bits");
    a_uplink_addr: assert property (
        uplinkInterruptProgram |-> memAddr == IIS_ADDR_UPLINK)
        else $error("uplink signal for another counter");
endmodule
bind iis_sequencer iis_properties i_props (.*);
`default_nettype wire

// ### iis_sequencer.sv
// Involuntary instruction sequencer: interrupt entry, resume and the four
// counter instructions, plus an APB slave for control and observation.
// Assumes priority control and the erasable memory share core_clk; memory
// read data is valid from the action after the address is presented.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module iis_sequencer
    import iis_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Erasable memory
    output logic [11:0] memAddr,
    output logic memWriteEnable,
    output logic [14:0] memWriteData,
    output logic memWriteParity,
    input wire logic [14:0] memReadData,
    input wire logic memReadParity,
    // Interrupt priority control
    input wire logic interruptRequest,
    input wire logic [11:0] vectorAddress,
    output logic clearInterruptRequestPulse,
    output logic interruptPriorityReset,
    output logic uplinkInterruptProgram,
    // Counter priority control
    input wire logic counterRequest,
    input wire logic [1:0] counterKind,
    input wire logic [11:0] counterAddress,
    output logic counterPriorityReset,
    output logic counterOverflow,
    // Sequencer observation
    output logic resumeSelectPulse,
    output logic overflowTestPulse,
    output logic [1:0] overflowTestBits,
    output logic parityAlarm
);
    iis_adder_if adderBus ();
    logic [3:0] action;
    logic [1:0] control;
    iis_step_type step;
    iis_step_type afterStep;
    iis_step_type pendingStep;
    iis_counter_kind_type kind;
    logic [11:0] programCounter;
    logic [14:0] bufferWord;
    logic [11:0] addressReg;
    logic [2:0] sequenceRegister;
    logic interruptInProgress;
    logic bufferHeld;
    logic parityBad;
    logic parityStatus;
    logic [15:0] adderX;
    logic [15:0] adderY;
    logic adderCarry;
    logic [15:0] readExtended;
    logic [14:0] writeWord;
    logic overflowNow;
    logic reverseCounter;
    logic shiftKind;
    logic trueSign;
    logic endOfInstruction;
    logic takeInterrupt;
    logic isResumeWord;
    logic apbSetup;
    logic apbAccess;
    logic [31:0] readValue;
    logic mapped;

    iis_action_timer timer (
        .core_clk(core_clk),
        .reset(reset),
        .run(control[IIS_CTL_RUN]),
        .action(action)
    );

    iis_ones_adder adder (
        .bus(adderBus)
    );

    assign adderBus.operandX = adderX;
    assign adderBus.operandY = adderY;
    assign adderBus.carryIn = adderCarry;

    // Position 15 is copied into 16 so that bits 16 and 15 form the pair
    assign readExtended = {memReadData[14], memReadData};
    assign overflowNow = adderBus.sum[15] ^ adderBus.sum[14];
    assign reverseCounter = (addressReg >= IIS_ADDR_REVERSE_LO)
        && (addressReg <= IIS_ADDR_REVERSE_HI);
    assign shiftKind = (kind == IIS_CNT_SHIFT)
        || (kind == IIS_CNT_SHIFT_ADD_ONE);
    // Reversing the sign keeps the true sign bit instead of the overflow bit;
    // shifts keep it too, so the uplink flag climbs from 14 into 15
    assign trueSign = (overflowNow && reverseCounter) || shiftKind;
    assign writeWord = trueSign ? adderBus.sum[14:0]
        : {adderBus.sum[15], adderBus.sum[13:0]};
    assign isResumeWord = (bufferWord[14:12] == IIS_RESUME_ORDER)
        && (bufferWord[11:0] == IIS_ADDR_SAVE_WORD);
    assign endOfInstruction = (step == IIS_STEP_FETCH)
        || (step == IIS_STEP_RESUME);
    assign takeInterrupt = interruptRequest && !interruptInProgress
        && !control[IIS_CTL_INHIBIT];
    assign parityBad = (^{memReadData, memReadParity}) == 1'b0;

    // Step sequencing; a pending counter request wins over the next step
    always_ff @(posedge core_clk) begin
        if (reset) begin
            step <= IIS_STEP_FETCH;
            pendingStep <= IIS_STEP_FETCH;
        end else if (action == IIS_ACTION_LAST && control[IIS_CTL_RUN]) begin
            if (counterRequest) begin
                step <= IIS_STEP_COUNTER;
                pendingStep <= (step == IIS_STEP_COUNTER)
                    ? pendingStep : afterStep;
            end else if (step == IIS_STEP_COUNTER) begin
                step <= pendingStep;
            end else begin
                step <= afterStep;
            end
        end
    end

    // Choice of the step that normally follows the current one
    always_ff @(posedge core_clk) begin
        if (reset) begin
            afterStep <= IIS_STEP_FETCH;
        end else begin
            case (step)
                IIS_STEP_FETCH: begin
                    if (action == 4'hB) begin
                        if (isResumeWord) begin
                            afterStep <= IIS_STEP_INDEX;
                        end else if (takeInterrupt) begin
                            afterStep <= IIS_STEP_ENTRY_ONE;
                        end else begin
                            afterStep <= IIS_STEP_FETCH;
                        end
                    end
                end
                IIS_STEP_ENTRY_ONE: begin
                    if (action == 4'hB) begin
                        afterStep <= IIS_STEP_ENTRY_TWO;
                    end
                end
                IIS_STEP_ENTRY_TWO: begin
                    if (action == 4'hB) begin
                        afterStep <= IIS_STEP_FETCH;
                    end
                end
                IIS_STEP_INDEX: begin
                    if (action == 4'hA) begin
                        afterStep <= (addressReg == IIS_ADDR_SAVE_WORD)
                            ? IIS_STEP_RESUME : IIS_STEP_FETCH;
                    end
                end
                IIS_STEP_RESUME: begin
                    if (action == 4'hB) begin
                        afterStep <= IIS_STEP_FETCH;
                    end
                end
                IIS_STEP_COUNTER: begin
                    afterStep <= afterStep;
                end
                default: begin
                    afterStep <= IIS_STEP_FETCH;
                end
            endcase
        end
    end

    // Address register and memory port
    always_ff @(posedge core_clk) begin
        if (reset) begin
            addressReg <= 12'h000;
            memAddr <= 12'h000;
            memWriteEnable <= 1'b0;
            memWriteData <= 15'h0000;
            memWriteParity <= 1'b0;
        end else begin
            memWriteEnable <= 1'b0;
            if (action == 4'h1) begin
                case (step)
                    IIS_STEP_FETCH: begin
                        addressReg <= programCounter;
                        memAddr <= programCounter;
                    end
                    IIS_STEP_ENTRY_ONE, IIS_STEP_RESUME: begin
                        addressReg <= IIS_ADDR_SAVE_NEXT;
                        memAddr <= IIS_ADDR_SAVE_NEXT;
                    end
                    IIS_STEP_ENTRY_TWO, IIS_STEP_INDEX: begin
                        addressReg <= IIS_ADDR_SAVE_WORD;
                        memAddr <= IIS_ADDR_SAVE_WORD;
                    end
                    IIS_STEP_COUNTER: begin
                        addressReg <= counterAddress;
                        memAddr <= counterAddress;
                    end
                    default: begin
                        addressReg <= addressReg;
                    end
                endcase
            end
            if (action == 4'h9 && step == IIS_STEP_ENTRY_ONE) begin
                memWriteEnable <= 1'b1;
                memWriteData <= {3'h0, programCounter};
                memWriteParity <= ~^{3'h0, programCounter};
            end
            if (action == 4'hA && step == IIS_STEP_ENTRY_TWO) begin
                memWriteEnable <= 1'b1;
                memWriteData <= bufferWord;
                memWriteParity <= ~^bufferWord;
            end
            if (action == 4'hA && step == IIS_STEP_COUNTER) begin
                memWriteEnable <= 1'b1;
                memWriteData <= writeWord;
                memWriteParity <= trueSign ? ~^writeWord : adderBus.sumParity;
            end
        end
    end

    // Program counter, instruction buffer and sequence register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            programCounter <= 12'h000;
            bufferWord <= 15'h0000;
            sequenceRegister <= 3'h0;
            bufferHeld <= 1'b0;
        end else begin
            case (step)
                IIS_STEP_FETCH: begin
                    // After resume the buffer already holds the instruction
                    if (action == 4'h6 && !bufferHeld) begin
                        bufferWord <= memReadData;
                    end
                    if (action == 4'h7 && !bufferHeld) begin
                        programCounter <= programCounter + 12'h001;
                    end
                    if (action == IIS_ACTION_LAST) begin
                        sequenceRegister <= bufferWord[14:12];
                        bufferHeld <= 1'b0;
                    end
                end
                IIS_STEP_ENTRY_ONE: begin
                    if (action == 4'hA) begin
                        programCounter <= IIS_ADDR_SAVE_WORD;
                    end
                end
                IIS_STEP_ENTRY_TWO: begin
                    if (action == 4'h2) begin
                        programCounter <= vectorAddress;
                    end
                end
                IIS_STEP_INDEX: begin
                    if (action == 4'h6) begin
                        bufferWord <= memReadData;
                    end
                end
                IIS_STEP_RESUME: begin
                    if (action == 4'h7) begin
                        programCounter <= memReadData[11:0];
                    end
                    if (action == IIS_ACTION_LAST) begin
                        sequenceRegister <= bufferWord[14:12];
                        bufferHeld <= 1'b1;
                    end
                end
                default: begin
                    bufferHeld <= bufferHeld;
                end
            endcase
        end
    end

    // Interrupt-in-progress and priority control strobes
    always_ff @(posedge core_clk) begin
        if (reset) begin
            interruptInProgress <= 1'b0;
            interruptPriorityReset <= 1'b0;
            clearInterruptRequestPulse <= 1'b0;
            resumeSelectPulse <= 1'b0;
        end else begin
            interruptPriorityReset <= 1'b0;
            clearInterruptRequestPulse <= 1'b0;
            resumeSelectPulse <= 1'b0;
            if (step == IIS_STEP_ENTRY_ONE && action == 4'h1) begin
                interruptInProgress <= 1'b1;
                interruptPriorityReset <= 1'b1;
            end else if (step == IIS_STEP_RESUME
                    && action == IIS_ACTION_LAST) begin
                interruptInProgress <= 1'b0;
            end
            if (step == IIS_STEP_ENTRY_TWO && action == 4'h3) begin
                clearInterruptRequestPulse <= 1'b1;
            end
            if (step == IIS_STEP_INDEX && action == 4'hA
                    && addressReg == IIS_ADDR_SAVE_WORD) begin
                resumeSelectPulse <= 1'b1;
            end
        end
    end

    // Counter arithmetic operands
    always_ff @(posedge core_clk) begin
        if (reset) begin
            kind <= IIS_CNT_INCREMENT;
            adderX <= 16'h0000;
            adderY <= 16'h0000;
            adderCarry <= 1'b0;
        end else if (step == IIS_STEP_COUNTER) begin
            if (action == 4'h1) begin
                kind <= iis_counter_kind_type'(counterKind);
                adderCarry <= 1'b0;
            end
            if (action == 4'h4) begin
                adderX <= 16'h0000;
                case (kind)
                    IIS_CNT_INCREMENT: adderY <= IIS_CONST_PLUS_ONE;
                    IIS_CNT_DECREMENT: adderY <= IIS_CONST_MINUS_ONE;
                    default: adderY <= 16'h0000;
                endcase
            end
            if (action == 4'h6) begin
                // Shifts clear bit 16 so no end-around carry returns the flag
                adderX <= shiftKind ? {1'b0, memReadData}
                    : readExtended;
                if (shiftKind) begin
                    adderY <= {1'b0, memReadData};
                end
            end
            if (action == 4'h7 && kind == IIS_CNT_SHIFT_ADD_ONE) begin
                adderCarry <= 1'b1;
            end
        end
    end

    // Counter results, alarms and uplink completion
    always_ff @(posedge core_clk) begin
        if (reset) begin
            counterPriorityReset <= 1'b0;
            counterOverflow <= 1'b0;
            overflowTestPulse <= 1'b0;
            overflowTestBits <= 2'h0;
            parityAlarm <= 1'b0;
            parityStatus <= 1'b0;
            uplinkInterruptProgram <= 1'b0;
        end else begin
            counterPriorityReset <= 1'b0;
            counterOverflow <= 1'b0;
            overflowTestPulse <= 1'b0;
            parityAlarm <= 1'b0;
            uplinkInterruptProgram <= 1'b0;
            if (step == IIS_STEP_COUNTER) begin
                // The flag bit reaching position 15 marks a full word
                if (action == 4'h6 && addressReg == IIS_ADDR_UPLINK
                        && memReadData[14]) begin
                    uplinkInterruptProgram <= 1'b1;
                end
                if (action == 4'h7 && parityBad) begin
                    parityAlarm <= 1'b1;
                end
                if (action == 4'hA) begin
                    overflowTestPulse <= 1'b1;
                    overflowTestBits <= adderBus.sum[15:14];
                    counterPriorityReset <= 1'b1;
                    counterOverflow <= overflowNow && !reverseCounter
                        && !shiftKind;
                end
            end
            // Sticky until software writes a one to the parity bit of the status register
            if (step == IIS_STEP_COUNTER && action == 4'h7 && parityBad) begin
                parityStatus <= 1'b1;
            end else if (apbAccess && pwrite && paddr == IIS_REG_STATUS
                    && pwdata[IIS_STA_PARITY]) begin
                parityStatus <= 1'b0;
            end
        end
    end

    // APB slave: answer prepared in setup, ready for exactly one access cycle
    assign apbSetup = psel && !penable;
    assign apbAccess = psel && penable && pready;

    always_comb begin
        readValue = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            IIS_REG_CONTROL: readValue[1:0] = control;
            IIS_REG_STATUS: begin
                readValue[IIS_STA_IN_PROGRESS] = interruptInProgress;
                readValue[IIS_STA_PARITY] = parityStatus;
                readValue[IIS_STA_STEP +: 3] = step;
                readValue[IIS_STA_ORDER +: 3] = sequenceRegister;
                readValue[IIS_STA_ACTION +: 4] = action;
            end
            IIS_REG_COUNTER: readValue[11:0] = programCounter;
            IIS_REG_BUFFER: readValue[14:0] = bufferWord;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (apbSetup) begin
            prdata <= pwrite ? 32'h0000_0000 : readValue;
            pready <= 1'b1;
            pslverr <= !mapped;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            control <= IIS_CONTROL_RESET;
        end else if (apbAccess && pwrite && paddr == IIS_REG_CONTROL) begin
            control <= pwdata[1:0];
        end
    end
endmodule
`default_nettype wire

// ### tb.sv
// Bench: counter instructions against an integer model, plus APB access.
// The bench plays priority control; iis_mem_model is the memory.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import iis_pkg::*;
    logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, memWriteEnable, memWriteParity, memReadParity;
    logic clearInterruptRequestPulse, interruptPriorityReset, err, up, ip, pa;
    logic uplinkInterruptProgram, counterPriorityReset, counterOverflow;
    logic resumeSelectPulse, overflowTestPulse, parityAlarm, top;
    logic interruptRequest = 0, counterRequest = 0;
    logic [11:0] memAddr, vectorAddress = 12'h000, counterAddress = 12'h000;
    logic [14:0] memWriteData, memReadData, w;
    logic [1:0] counterKind = 2'h0, overflowTestBits;
    integer num_errors = 0, n_checks = 0, seed = 18, s, n;
    iis_sequencer i_dut (.*);
    iis_mem_model i_mem (.*);
    always #50 core_clk = ~core_clk;
    task end_sim;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wait_for(input int lim);
        if (n >= lim) begin
            num_errors++;
            end_sim();
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1 && n < 50);
        wait_for(50);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge core_clk);
    endtask
    task ctr(input logic [1:0] kd, input logic [11:0] a, input logic [14:0] v,
        input logic bd);
        i_mem.mem[a] = {~^v ^ bd, v};
        counterKind <= kd;
        counterAddress <= a;
        counterRequest <= 1;
        // Shifts move the word without bit 16, so nothing wraps around
        s = (kd < 2 ? {v[14], v} : {1'b0, v})
            + (kd == 0 ? 1 : kd == 1 ? 'hFFFE : v);
        s = s + (kd == 3);
        if (s > 'hFFFF) s = s - 'hFFFF;
        top = (a >= IIS_ADDR_REVERSE_LO && a <= IIS_ADDR_REVERSE_HI);
        up = 0;
        pa = 0;
        n = 0;
        do begin
            @(posedge core_clk);
            up |= uplinkInterruptProgram;
            pa |= parityAlarm;
            n++;
        end while (counterPriorityReset !== 1 && n < 100);
        wait_for(100);
        counterRequest <= 0;
        chk(counterOverflow, kd < 2 && s[15] != s[14] && !top);
        chk(overflowTestBits, s[15:14]);
        chk(pa, bd);
        repeat (2) @(posedge core_clk);
        if (kd < 2)
            chk(i_mem.mem[a][14:0], {top ? s[14] : s[15], s[13:0]});
        else chk(i_mem.mem[a][14:0], s[14:0]);
        chk(up, a == IIS_ADDR_UPLINK && v[14]);
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 0;
        @(posedge core_clk);
        apb(0, IIS_REG_CONTROL, 0);
        chk(rd, 0);
        apb(0, 8'h10, 32'hFFFFFFFF);
        chk(err, 1);
        chk(rd, 0);
        apb(1, IIS_REG_CONTROL, 1);
        w = 15'($random(seed));
        ctr(0, 12'o0044, w & 15'h0FFF, 0);
        ctr(1, 12'o0044, 15'h0000, 0);
        ctr(0, 12'o0044, 15'o37777, 0);
        ctr(0, 12'o0050, 15'o37777, 0);
        ctr(1, 12'o0053, 15'o40000, 0);
        ctr(2, IIS_ADDR_UPLINK, {2'b01, w[12:0]}, 0);
        ctr(2, IIS_ADDR_UPLINK, {1'b1, w[13:0]}, 0);
        ctr(3, 12'o0042, w, 1);
        // Vector location holds the resume word, so entry runs straight back
        i_mem.mem[12'o2004] = {~^{IIS_RESUME_ORDER, IIS_ADDR_SAVE_WORD},
            IIS_RESUME_ORDER, IIS_ADDR_SAVE_WORD};
        interruptRequest <= 1;
        vectorAddress <= 12'o2004;
        ip = 0;
        n = 0;
        do begin
            @(posedge core_clk);
            ip |= interruptPriorityReset;
            n++;
        end while (clearInterruptRequestPulse !== 1 && n < 100);
        wait_for(100);
        interruptRequest <= 0;
        chk(ip, 1);
        apb(0, IIS_REG_STATUS, 0);
        chk(rd[IIS_STA_IN_PROGRESS], 1);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (resumeSelectPulse !== 1 && n < 100);
        wait_for(100);
        // Stop while the first fetch after resume still holds the counter
        repeat (14) @(posedge core_clk);
        apb(1, IIS_REG_CONTROL, 0);
        apb(0, IIS_REG_COUNTER, 0);
        chk(rd[11:0], i_mem.mem[IIS_ADDR_SAVE_NEXT][11:0]);
        apb(0, IIS_REG_STATUS, 0);
        chk(rd[IIS_STA_IN_PROGRESS], 0);
        end_sim();
    end
endmodule
`default_nettype wire
